// File: pkg/pvp_pkg.sv
`default_nettype none
package pvp_pkg;

    // system clock and link timing
    localparam int CLK_NS          = 10;
    localparam int SCK_HALF_NS     = 100;
    localparam int SCK_HALF_CYC    = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_US          = 1;
    localparam int GAP_CYC         = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_NS       = 5000;
    localparam int SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HALF_LD = 8'(SCK_HALF_CYC - 1);
    localparam logic [9:0] GAP_LD  = 10'(GAP_CYC - 1);
    localparam logic [9:0] SET_LD  = 10'(SETTLE_CYC - 1);

    // frame shapes
    localparam logic [4:0] CMD_BITS   = 5'h06;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [3:0] DATA_FIRST = 4'h1;
    localparam logic [3:0] DATA_LAST  = 4'hE;
    localparam logic [3:0] DM_LAST    = 4'h8;

    // six-bit command codes
    localparam logic [5:0] CMD_LOAD_CFG   = 6'h00;
    localparam logic [5:0] CMD_LOAD_PROG  = 6'h02;
    localparam logic [5:0] CMD_READ_PROG  = 6'h04;
    localparam logic [5:0] CMD_INC_ADDR   = 6'h06;
    localparam logic [5:0] CMD_BEGIN      = 6'h08;
    localparam logic [5:0] CMD_BEGIN_ONLY = 6'h18;
    localparam logic [5:0] CMD_LOAD_DM    = 6'h03;
    localparam logic [5:0] CMD_READ_DM    = 6'h05;
    localparam logic [5:0] CMD_ERASE_PROG = 6'h09;
    localparam logic [5:0] CMD_ERASE_DM   = 6'h0B;

    // address counter mirror
    localparam logic [13:0] ADDR_RST  = 14'h0000;
    localparam logic [13:0] CFG_BASE  = 14'h2000;

    typedef enum logic [3:0] {
        OP_ENTER, OP_EXIT, OP_LOAD_CFG, OP_LOAD_PROG, OP_READ_PROG,
        OP_INC_ADDR, OP_BEGIN, OP_BEGIN_ONLY, OP_LOAD_DM, OP_READ_DM,
        OP_ERASE_PROG, OP_ERASE_DM
    } pvp_op_e;

    typedef struct packed {
        pvp_op_e     op;
        logic [13:0] data;
    } pvp_cmd_s;

    typedef struct packed {
        logic        err;
        logic [13:0] data;
    } pvp_rsp_s;

    // only the begin-only code differs between variants
    function automatic logic [5:0] pvp_code(input pvp_op_e op,
                                            input logic    variant2);
        unique case (op)
            OP_LOAD_CFG:   pvp_code = CMD_LOAD_CFG;
            OP_LOAD_PROG:  pvp_code = CMD_LOAD_PROG;
            OP_READ_PROG:  pvp_code = CMD_READ_PROG;
            OP_INC_ADDR:   pvp_code = CMD_INC_ADDR;
            OP_BEGIN_ONLY: pvp_code = variant2 ? CMD_BEGIN_ONLY : CMD_BEGIN;
            OP_LOAD_DM:    pvp_code = CMD_LOAD_DM;
            OP_READ_DM:    pvp_code = CMD_READ_DM;
            OP_ERASE_PROG: pvp_code = CMD_ERASE_PROG;
            OP_ERASE_DM:   pvp_code = CMD_ERASE_DM;
            default:       pvp_code = CMD_BEGIN;
        endcase
    endfunction : pvp_code

    function automatic logic pvp_is_read(input pvp_op_e op);
        pvp_is_read = (op == OP_READ_PROG) || (op == OP_READ_DM);
    endfunction : pvp_is_read

    function automatic logic pvp_is_load(input pvp_op_e op);
        pvp_is_load = (op == OP_LOAD_CFG) || (op == OP_LOAD_PROG)
                   || (op == OP_LOAD_DM);
    endfunction : pvp_is_load

endpackage : pvp_pkg
`default_nettype wire

// File: design/pvp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pvp_sync
    import pvp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic out;
    } pvp_sync_s;

    pvp_sync_s s;
    pvp_sync_s next_s;

    // meta feeds only the second stage
    always_comb begin
        next_s.meta = d;
        next_s.out  = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.out;
endmodule : pvp_sync
`default_nettype wire

// File: design/pvp_bitgen.sv
`timescale 1ns/1ns
`default_nettype none
module pvp_bitgen
    import pvp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [4:0] nbits,
    output logic            sclk,
    output logic            rise,
    output logic            fall,
    output logic            done,
    output logic            busy,
    output logic [3:0]      idx
);
    typedef struct packed {
        logic       active;
        logic       lvl;
        logic [7:0] cnt;
        logic [3:0] idx;
        logic [3:0] last;
    } pvp_bg_s;

    pvp_bg_s s;
    pvp_bg_s next_s;
    logic    tick;

    // link clock divided from clk, so no second domain is needed
    always_comb begin
        next_s = s;
        tick   = s.active && (s.cnt == 8'h00);
        rise   = tick && !s.lvl;
        fall   = tick && s.lvl;
        done   = fall && (s.idx == s.last);
        if (start && !s.active) begin
            next_s.active = 1'b1;
            next_s.lvl    = 1'b0;
            next_s.cnt    = HALF_LD;
            next_s.idx    = 4'h0;
            next_s.last   = 4'(nbits - 5'h01);
        end else if (tick) begin
            next_s.lvl = !s.lvl;
            next_s.cnt = HALF_LD;
            if (fall) begin
                // clock rests low between frames
                if (done) begin
                    next_s.active = 1'b0;
                end else begin
                    next_s.idx = s.idx + 4'h1;
                end
            end
        end else if (s.active) begin
            next_s.cnt = s.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sclk = s.lvl;
    assign busy = s.active;
    assign idx  = s.idx;

    a_frame_count: assert property (@(posedge clk) disable iff (!rst_n)
        (fall && s.idx == s.last) |=> !s.active && !s.lvl)
        else $error("frame did not end after its last falling edge");
endmodule : pvp_bitgen
`default_nettype wire

// File: design/pvp_programmer.sv
`timescale 1ns/1ns
`default_nettype none
module pvp_programmer
    import pvp_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  variant_two,
    input  wire logic  cmd_valid,
    output logic       cmd_ready,
    input  wire pvp_cmd_s cmd,
    output logic       rsp_valid,
    output pvp_rsp_s   rsp,
    output logic [13:0] addr_mirror,
    output logic       cfg_space,
    output logic       mode_select_pin,
    output logic       osc_hold,
    output logic       serial_clock_pin,
    output logic       serial_data_out,
    output logic       serial_data_oe_n,
    input  wire logic  serial_data_in
);
    typedef enum logic [3:0] {
        ST_OFF, ST_ENTRY_LOW, ST_ENTRY_RISE, ST_READY, ST_CMD,
        ST_GAP, ST_FRAME, ST_TAIL, ST_EXIT
    } pvp_st_e;

    typedef struct packed {
        pvp_st_e     st;
        pvp_op_e     op;
        logic [13:0] wdata;
        logic [13:0] rdata;
        logic [5:0]  code;
        logic [13:0] addr;
        logic        loaded;
        logic        mode;
        logic        osc;
        logic        dout;
        logic        drive;
        logic [9:0]  wait_cnt;
        logic        rsp_v;
        logic        rsp_err;
    } pvp_main_s;

    pvp_main_s  s;
    pvp_main_s  next_s;
    logic [1:0] rst_q;
    logic       rst_ni;
    logic       din;
    logic       bg_start;
    logic [4:0] bg_nbits;
    logic       bg_sclk;
    logic       bg_rise;
    logic       bg_fall;
    logic       bg_done;
    logic       bg_busy;
    logic [3:0] bg_idx;
    logic [9:0] since_done;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_ni = rst_q[1];

    // device drives data from outside this clock domain
    pvp_sync u_din_sync (
        .clk   (clk),
        .rst_n (rst_ni),
        .d     (serial_data_in),
        .q     (din)
    );

    pvp_bitgen u_bitgen (
        .clk   (clk),
        .rst_n (rst_ni),
        .start (bg_start),
        .nbits (bg_nbits),
        .sclk  (bg_sclk),
        .rise  (bg_rise),
        .fall  (bg_fall),
        .done  (bg_done),
        .busy  (bg_busy),
        .idx   (bg_idx)
    );

    // bit value for a frame slot: zero start and stop, data between
    function automatic logic frame_bit(input logic [13:0] w,
                                       input logic [3:0]  i,
                                       input logic        dm);
        logic [3:0] last;
        last = dm ? DM_LAST : DATA_LAST;
        if (i < DATA_FIRST || i > last) begin
            frame_bit = 1'b0;
        end else begin
            frame_bit = w[4'(i - DATA_FIRST)];
        end
    endfunction : frame_bit

    // mirror of the device counter, sticky once in configuration space
    function automatic logic [13:0] addr_next(input logic [13:0] a);
        addr_next = {a[13], 13'(a[12:0] + 13'h0001)};
    endfunction : addr_next

    assign cmd_ready = (s.st == ST_OFF) || (s.st == ST_READY);

    // sequencer: entry, six-clock command, gap, optional frame, gap
    always_comb begin
        next_s       = s;
        next_s.rsp_v = 1'b0;
        bg_start     = 1'b0;
        bg_nbits     = CMD_BITS;
        unique case (s.st)
            ST_OFF: begin
                if (cmd_valid) begin
                    next_s.rsp_v   = (cmd.op != OP_ENTER);
                    next_s.rsp_err = (cmd.op != OP_ENTER);
                    if (cmd.op == OP_ENTER) begin
                        // pins low and oscillator quiet before mode rises
                        next_s.st       = ST_ENTRY_LOW;
                        next_s.osc      = 1'b1;
                        next_s.wait_cnt = SET_LD;
                    end
                end
            end
            ST_ENTRY_LOW: begin
                if (s.wait_cnt == 10'h000) begin
                    next_s.st       = ST_ENTRY_RISE;
                    next_s.mode     = 1'b1;
                    next_s.wait_cnt = SET_LD;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 10'h001;
                end
            end
            ST_ENTRY_RISE: begin
                if (s.wait_cnt == 10'h000) begin
                    // device has reset into user memory at address zero
                    next_s.st      = ST_READY;
                    next_s.addr    = ADDR_RST;
                    next_s.loaded  = 1'b0;
                    next_s.rsp_v   = 1'b1;
                    next_s.rsp_err = 1'b0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 10'h001;
                end
            end
            ST_READY: begin
                if (cmd_valid) begin
                    next_s.op    = cmd.op;
                    next_s.wdata = cmd.data;
                    next_s.rdata = 14'h0000;
                    if (cmd.op == OP_ENTER) begin
                        next_s.rsp_v   = 1'b1;
                        next_s.rsp_err = 1'b1;
                    end else if (cmd.op == OP_EXIT) begin
                        next_s.st       = ST_EXIT;
                        next_s.mode     = 1'b0;
                        next_s.wait_cnt = SET_LD;
                    end else if ((cmd.op == OP_BEGIN
                               || cmd.op == OP_BEGIN_ONLY)
                               && !s.loaded) begin
                        // a write without fresh data is refused
                        next_s.rsp_v   = 1'b1;
                        next_s.rsp_err = 1'b1;
                    end else begin
                        next_s.st    = ST_CMD;
                        next_s.code  = pvp_code(cmd.op, variant_two);
                        next_s.drive = 1'b1;
                        bg_start     = 1'b1;
                        bg_nbits     = CMD_BITS;
                    end
                end
            end
            ST_CMD: begin
                if (bg_rise) begin
                    next_s.dout = s.code[3'(bg_idx)];
                end
                if (bg_done) begin
                    next_s.st       = ST_GAP;
                    next_s.wait_cnt = GAP_LD;
                    unique case (s.op)
                        OP_LOAD_CFG: next_s.addr = CFG_BASE;
                        OP_INC_ADDR: next_s.addr = addr_next(s.addr);
                        default:     next_s.addr = s.addr;
                    endcase
                    if (pvp_is_load(s.op)) begin
                        next_s.loaded = 1'b1;
                    end else if (s.op == OP_BEGIN
                              || s.op == OP_BEGIN_ONLY) begin
                        next_s.loaded = 1'b0;
                    end
                end
            end
            ST_GAP: begin
                // release a clock after the last fall so hold time is kept
                if (pvp_is_read(s.op)) begin
                    next_s.drive = 1'b0;
                end
                if (s.wait_cnt == 10'h000) begin
                    next_s.dout = 1'b0;
                    if (pvp_is_read(s.op) || pvp_is_load(s.op)) begin
                        next_s.st = ST_FRAME;
                        // id words carry only their low nibble
                        if (pvp_is_load(s.op) && s.op != OP_LOAD_DM
                            && s.addr[13] && s.addr[12:2] == 11'h000) begin
                            next_s.wdata = {10'h000, s.wdata[3:0]};
                        end
                        bg_start  = 1'b1;
                        bg_nbits  = FRAME_BITS;
                    end else begin
                        next_s.st      = ST_READY;
                        next_s.rsp_v   = 1'b1;
                        next_s.rsp_err = 1'b0;
                    end
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 10'h001;
                end
            end
            ST_FRAME: begin
                if (bg_rise && !pvp_is_read(s.op)) begin
                    // data memory keeps eight bits, rest sent as zero
                    next_s.dout = frame_bit(s.wdata, bg_idx,
                                            s.op == OP_LOAD_DM);
                end
                if (bg_fall && pvp_is_read(s.op)
                    && bg_idx >= DATA_FIRST && bg_idx <= DATA_LAST) begin
                    // device changed the bit a half period earlier
                    next_s.rdata[4'(bg_idx - DATA_FIRST)] = din;
                end
                if (bg_done) begin
                    next_s.st       = ST_TAIL;
                    next_s.wait_cnt = GAP_LD;
                end
            end
            ST_TAIL: begin
                if (s.wait_cnt == 10'h000) begin
                    next_s.st      = ST_READY;
                    next_s.drive   = 1'b1;
                    next_s.dout    = 1'b0;
                    next_s.rsp_v   = 1'b1;
                    next_s.rsp_err = 1'b0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 10'h001;
                end
            end
            ST_EXIT: begin
                if (s.wait_cnt == 10'h000) begin
                    // oscillator released only after mode select settles
                    next_s.st      = ST_OFF;
                    next_s.osc     = 1'b0;
                    next_s.addr    = ADDR_RST;
                    next_s.loaded  = 1'b0;
                    next_s.rsp_v   = 1'b1;
                    next_s.rsp_err = 1'b0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 10'h001;
                end
            end
            default: begin
                next_s.st = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_ni) begin
        if (!rst_ni) begin
            s       <= '0;
            s.st    <= ST_OFF;
            s.op    <= OP_ENTER;
            s.drive <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // cycles since the last command or frame ended, used only to check spacing
    always_ff @(posedge clk or negedge rst_ni) begin
        if (!rst_ni) begin
            since_done <= GAP_LD;
        end else if (bg_done) begin
            since_done <= 10'h000;
        end else if (since_done != 10'h3FF) begin
            since_done <= since_done + 10'h001;
        end
    end

    assign rsp_valid        = s.rsp_v;
    assign rsp              = '{err: s.rsp_err, data: s.rdata};
    assign addr_mirror      = s.addr;
    assign cfg_space        = s.addr[13];
    assign mode_select_pin  = s.mode;
    assign osc_hold         = s.osc;
    assign serial_clock_pin = bg_sclk;
    assign serial_data_out  = s.dout;
    assign serial_data_oe_n = !s.drive;

    a_entry_pins: assert property (@(posedge clk) disable iff (!rst_ni)
        $rose(mode_select_pin) |-> !serial_clock_pin && !serial_data_oe_n
                                   && !serial_data_out)
        else $error("mode select rose while serial pins not held low");

    a_osc_quiet: assert property (@(posedge clk) disable iff (!rst_ni)
        $changed(mode_select_pin) |-> osc_hold && $past(osc_hold))
        else $error("oscillator not held while mode select moved");

    a_cmd_gap: assert property (@(posedge clk) disable iff (!rst_ni)
        bg_start |-> since_done >= GAP_LD)
        else $error("less than the minimum gap before a transfer");

    a_cmd_bits: assert property (@(posedge clk) disable iff (!rst_ni)
        (s.st == ST_CMD && bg_rise) |=> serial_data_out == s.code[3'(bg_idx)])
        else $error("command bit out of order");

    a_change_rise: assert property (@(posedge clk) disable iff (!rst_ni)
        (!serial_data_oe_n && $changed(serial_data_out)
         && (s.st == ST_CMD || s.st == ST_FRAME)
         && $past(s.st) == s.st) |-> $rose(serial_clock_pin))
        else $error("data changed away from a rising edge");

    a_read_release: assert property (@(posedge clk) disable iff (!rst_ni)
        (s.st == ST_FRAME && pvp_is_read(s.op)) |-> serial_data_oe_n)
        else $error("host drove data during a read frame");

    a_stop_bits: assert property (@(posedge clk) disable iff (!rst_ni)
        ($rose(serial_clock_pin) && s.st == ST_FRAME && !pvp_is_read(s.op)
         && (bg_idx == 4'h0 || bg_idx == 4'hF)) |-> !serial_data_out)
        else $error("start or stop bit not zero");

    a_dm_narrow: assert property (@(posedge clk) disable iff (!rst_ni)
        ($rose(serial_clock_pin) && s.st == ST_FRAME && s.op == OP_LOAD_DM
         && bg_idx > DM_LAST) |-> !serial_data_out)
        else $error("data memory load sent bits past the eighth");

    a_begin_loaded: assert property (@(posedge clk) disable iff (!rst_ni)
        (s.st == ST_CMD && (s.op == OP_BEGIN || s.op == OP_BEGIN_ONLY))
        |-> s.loaded)
        else $error("begin programming without a preceding load");
endmodule : pvp_programmer
`default_nettype wire

// File: dv/pvp_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module pvp_dev_model (
    input  wire logic mode_sel,
    input  wire logic sclk,
    input  wire logic host_d,
    input  wire logic host_oe_n,
    output logic      pin
);
    logic [13:0] prog [1024];
    logic [13:0] cfg  [16];
    logic [7:0]  dm   [64];
    logic [13:0] acnt, ld, rw;
    logic [15:0] fr;
    logic [5:0]  cmd;
    logic [3:0]  lc;
    int          n = 0, r = 0;
    logic        infr = 0, rd = 0, drv = 0, dv = 0, last = 0;
    // released line shows the inverse of its last level, never a stale copy
    assign pin = !host_oe_n ? host_d : (drv && mode_sel) ? dv : ~last;
    // falling edge: every bit is latched here, commands and frames alike
    always @(negedge sclk or negedge mode_sel) begin
        if (!mode_sel) begin
            acnt = 14'h0000;
            n = 0;
            infr = 0;
        end else begin
            last = pin;
            n = n + 1;
            if (!infr) begin
                cmd = {pin, cmd[5:1]};
                if (n == 6) begin
                    n = 0;
                    rd = cmd[3:0] inside {4'h4, 4'h5};
                    rw = (acnt[13] && acnt[12:4] == 9'h000) ? cfg[acnt[3:0]]
                        : prog[acnt[9:0]];
                    if (cmd[3:0] == 4'h5) rw = {6'h00, dm[acnt[5:0]]};
                    case (cmd[3:0])
                        4'h0: begin
                            acnt = 14'h2000;
                            infr = 1;
                        end
                        4'h2, 4'h3, 4'h4, 4'h5: infr = 1;
                        4'h6: acnt = {acnt[13], acnt[12:0] + 13'h0001};
                        4'h8: begin // only latched data is written
                            if (lc == 4'h3) dm[acnt[5:0]] = ld[7:0];
                            else if (acnt[13] && acnt[12:4] == 9'h000)
                                cfg[acnt[3:0]] = ld;
                            else prog[acnt[9:0]] = ld;
                        end
                        default: ;
                    endcase
                end
            end else begin
                fr = {pin, fr[15:1]};
                if (n == 16) begin
                    n = 0;
                    infr = 0;
                    lc = rd ? lc : cmd[3:0];
                    if (!rd) ld = (cmd[3:0] == 4'h3) ? {6'h00, fr[8:1]}
                        : fr[14:1];
                end
            end
        end
    end
    // read frames drive from the 2nd rising edge, release at the 16th
    always @(posedge sclk) begin
        r = (infr && rd) ? r + 1 : 0;
        drv = r >= 2 && r < 16;
        if (drv) dv = rw[r-2];
    end
endmodule : pvp_dev_model
`default_nettype wire

// File: dv/tb_pvp_programmer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pvp_programmer
    import pvp_pkg::*;
;
    logic        clk = 0, rst_n = 0, variant_two = 0, cmd_valid = 0;
    pvp_cmd_s    cmd = '0;
    pvp_rsp_s    rsp;
    logic [13:0] addr_mirror;
    logic        cmd_ready, rsp_valid, cfg_space, msp, osc_hold;
    logic        sclk, sdo, sdoe_n, sdi;
    int          n_errors = 0, compares = 0, cyc = 0;
    pvp_programmer dut (.clk(clk), .rst_n(rst_n), .variant_two(variant_two),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .addr_mirror(addr_mirror),
        .cfg_space(cfg_space), .mode_select_pin(msp), .osc_hold(osc_hold),
        .serial_clock_pin(sclk), .serial_data_out(sdo),
        .serial_data_oe_n(sdoe_n), .serial_data_in(sdi));
    pvp_dev_model dev (.mode_sel(msp), .sclk(sclk), .host_d(sdo),
        .host_oe_n(sdoe_n), .pin(sdi));
    initial forever #5 clk = ~clk;
    // hang guard, about twice the ~9k cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("mismatch at %0t: run did not finish", $time);
            final_report;
        end
    end
    always @(posedge msp) if (rst_n) chk(sclk | sdi, 14'h0000);
    always @(msp) if (rst_n) chk(osc_hold, 14'h0001);
    task automatic chk(input logic [13:0] a, input logic [13:0] b);
        compares++;
        if (a !== b) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, a, b);
        end
    endtask : chk
    // one command: hold valid until taken, then wait for the answer
    task automatic op(input pvp_op_e o, input logic [13:0] d,
                      input logic e, input logic [13:0] x);
        int k;
        @(negedge clk);
        cmd_valid = 1;
        cmd = '{o, d};
        // ready is judged half a cycle ahead of the edge that takes it
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk(14'(rsp_valid), 14'h0001);
        chk(rsp.err, e);
        if (!e) chk(rsp.data, x);
    endtask : op
    task automatic t_entry;
        op(OP_LOAD_PROG, 14'h0001, 1, 14'h0000);
        op(OP_ENTER, 14'h0000, 0, 14'h0000);
        chk(addr_mirror, 14'h0000);
    endtask : t_entry
    task automatic t_prog;
        op(OP_LOAD_PROG, 14'h2A5C, 0, 14'h0000);
        op(OP_BEGIN, 14'h0000, 0, 14'h0000);
        chk(14'(dev.cmd), 14'h0008);
        op(OP_BEGIN, 14'h0000, 1, 14'h0000);
        op(OP_READ_PROG, 14'h0000, 0, 14'h2A5C);
        op(OP_INC_ADDR, 14'h0000, 0, 14'h0000);
        chk(addr_mirror, 14'h0001);
    endtask : t_prog
    task automatic t_dm;
        op(OP_LOAD_DM, 14'h3F5A, 0, 14'h0000);
        op(OP_ERASE_DM, 14'h0000, 0, 14'h0000);
        op(OP_BEGIN, 14'h0000, 0, 14'h0000);
        op(OP_READ_DM, 14'h0000, 0, 14'h005A);
        op(OP_ERASE_PROG, 14'h0000, 0, 14'h0000);
    endtask : t_dm
    task automatic t_cfg;
        variant_two = 1;
        op(OP_LOAD_CFG, 14'h1234, 0, 14'h0000);
        chk(14'(cfg_space), 14'h0001);
        chk(addr_mirror, 14'h2000);
        op(OP_BEGIN_ONLY, 14'h0000, 0, 14'h0000);
        chk(14'(dev.cmd), 14'h0018);
        op(OP_READ_PROG, 14'h0000, 0, 14'h0004);
        op(OP_INC_ADDR, 14'h0000, 0, 14'h0000);
        chk(addr_mirror, 14'h2001);
        op(OP_ENTER, 14'h0000, 1, 14'h0000);
    endtask : t_cfg
    task automatic t_reenter;
        op(OP_EXIT, 14'h0000, 0, 14'h0000);
        chk(addr_mirror, 14'h0000);
        variant_two = 0;
        op(OP_ENTER, 14'h0000, 0, 14'h0000);
        op(OP_READ_PROG, 14'h0000, 0, 14'h2A5C);
    endtask : t_reenter
    task automatic final_report;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        t_entry;
        t_prog;
        t_dm;
        t_cfg;
        t_reenter;
        final_report;
    end
endmodule : tb_pvp_programmer
`default_nettype wire
